// *** pprs_consts.svh ***
`ifndef PPRS_CONSTS_SVH
`define PPRS_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define PPRS_ADDR_TABLE    8'h01
`define PPRS_ADDR_SERIAL_A 8'h02
`define PPRS_ADDR_SERIAL_B 8'h03
`define PPRS_ADDR_SPI      8'h04
`define PPRS_ADDR_TWO_WIRE 8'h05

// ****************************************
// Reset values and writable bits
// ****************************************
`define PPRS_RESET_VAL     8'h00
`define PPRS_MASK_TABLE    8'h03
`define PPRS_MASK_SERIAL_A 8'hff
`define PPRS_MASK_SERIAL_B 8'h03
`define PPRS_MASK_SPI      8'h0f
`define PPRS_MASK_TWO_WIRE 8'h0c

// ****************************************
// Field positions
// ****************************************
`define PPRS_TABLE0_BIT    0
`define PPRS_TABLE1_BIT    1
`define PPRS_SERIAL0_LSB   0
`define PPRS_SERIAL1_LSB   2
`define PPRS_SERIAL2_LSB   4
`define PPRS_SERIAL3_LSB   6
`define PPRS_SERIAL4_LSB   0
`define PPRS_SPI_FIRST_LSB 0
`define PPRS_SPI_SECOND_LSB 2
`define PPRS_TWO_WIRE_LSB  2

// ****************************************
// Pin numbering: port base plus bit
// ****************************************
`define PPRS_PA            6'h00
`define PPRS_PB            6'h08
`define PPRS_PC            6'h10
`define PPRS_PE            6'h18
`define PPRS_PF            6'h20
`define PPRS_NOPIN         6'h3f
`define PPRS_NUM_PINS      40
`define PPRS_NUM_UNITS     10

`endif

// *** pprs_pkg.sv ***
package pprs_pkg;

	typedef logic [5:0] pprs_pin_t;
	typedef logic [23:0] pprs_map_t;

	typedef enum logic [1:0] {
		PPRS_CODE_DEFAULT = 2'b00,
		PPRS_CODE_ALTERNATE_POSITION_1    = 2'b01,
		PPRS_CODE_ALTERNATE_POSITION_2    = 2'b10,
		PPRS_CODE_NONE    = 2'b11
	} pprs_code_e;

	typedef enum logic [3:0] {
		PPRS_U_TABLE0   = 4'b0000,
		PPRS_U_TABLE1   = 4'b0001,
		PPRS_U_SERIAL0  = 4'b0010,
		PPRS_U_SERIAL1  = 4'b0011,
		PPRS_U_SERIAL2  = 4'b0100,
		PPRS_U_SERIAL3  = 4'b0101,
		PPRS_U_SERIAL4  = 4'b0110,
		PPRS_U_SPI_A    = 4'b0111,
		PPRS_U_SPI_B    = 4'b1000,
		PPRS_U_TWO_WIRE = 4'b1001
	} pprs_unit_e;

endpackage

// *** pprs_lane_if.sv ***
`timescale 1ns/100ps

interface pprs_lane_if;
	logic [23:0] map;
	logic [3:0]  o;
	logic [3:0]  oe;
	logic [3:0]  i;
	logic [39:0] pin_in;
	logic [39:0] drv_o;
	logic [39:0] drv_oe;

	modport route (
		input  map,
		input  o,
		input  oe,
		input  pin_in,
		output i,
		output drv_o,
		output drv_oe
	);

	modport owner (
		output map,
		output o,
		output oe,
		output pin_in,
		input  i,
		input  drv_o,
		input  drv_oe
	);
endinterface

// *** pprs_route4.sv ***
`timescale 1ns/100ps
`include "pprs_consts.svh"

// ****************************************
// One unit: four lanes placed on pins
// ****************************************
module pprs_route4 (
	pprs_lane_if.route lanes
);
	wire [5:0] lane_pin [4];
	wire [3:0] lane_on;

	genvar l;
	genvar p;
	generate
		for (l = 0; l < 4; l++) begin : g_lane
			assign lane_pin[l] = lanes.map[l*6 +: 6];
			assign lane_on[l]  = lane_pin[l] < 6'(`PPRS_NUM_PINS);
			// Unplaced lanes read low
			assign lanes.i[l]  = lane_on[l] ?
				lanes.pin_in[lane_pin[l]] : 1'b0;
		end
		for (p = 0; p < `PPRS_NUM_PINS; p++) begin : g_pin
			wire [3:0] hit;
			for (l = 0; l < 4; l++) begin : g_hit
				assign hit[l] = lane_pin[l] == 6'(p);
			end
			assign lanes.drv_oe[p] = |(hit & lanes.oe);
			assign lanes.drv_o[p]  = |(hit & lanes.oe & lanes.o);
		end
	endgenerate
endmodule

// *** pprs_top.sv ***
// Decided for this implementation: the plain strobed port.
`timescale 1ns/100ps
`include "pprs_consts.svh"

module pprs_top (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// Register port
	input  wire logic [7:0]  addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	output logic      [7:0]  rdata,
	// Peripheral lanes, unit times four plus lane
	input  wire logic [39:0] unit_o,
	input  wire logic [39:0] unit_oe,
	output logic      [39:0] unit_i,
	// Port pins, port base plus bit
	input  wire logic [39:0] pin_in,
	output logic      [39:0] pin_out,
	output logic      [39:0] pin_oe
);

	// ****************************************
	// Map helpers
	// ****************************************
	function automatic pprs_pkg::pprs_map_t pprs_seq(
		input pprs_pkg::pprs_pin_t first,
		input logic [2:0]          count
	);
		pprs_pkg::pprs_map_t r;
		// Lanes past the count stay unplaced
		r = {4{`PPRS_NOPIN}};
		for (int l = 0; l < 4; l++) begin
			if (3'(l) < count) begin
				r[l*6 +: 6] = first + 6'(l);
			end
		end
		return r;
	endfunction

	// Code 3 leaves the unit off every pin; code 2 takes the on_alternate_position_2 map
	function automatic pprs_pkg::pprs_map_t pprs_pick(
		input logic [1:0]          code,
		input pprs_pkg::pprs_map_t on_default,
		input pprs_pkg::pprs_map_t on_alternate_position_1,
		input pprs_pkg::pprs_map_t on_alternate_position_2
	);
		pprs_pkg::pprs_map_t r;
		unique case (pprs_pkg::pprs_code_e'(code))
			pprs_pkg::PPRS_CODE_DEFAULT: r = on_default;
			pprs_pkg::PPRS_CODE_ALTERNATE_POSITION_1:    r = on_alternate_position_1;
			pprs_pkg::PPRS_CODE_ALTERNATE_POSITION_2:    r = on_alternate_position_2;
			pprs_pkg::PPRS_CODE_NONE:    r = {4{`PPRS_NOPIN}};
		endcase
		return r;
	endfunction

	// ****************************************
	// Registers
	// ****************************************
	logic [7:0] table_q;
	logic [7:0] serial_a_q;
	logic [7:0] serial_b_q;
	logic [7:0] spi_q;
	logic [7:0] two_wire_q;
	logic [7:0] rdata_q;

	wire hit_table    = addr == `PPRS_ADDR_TABLE;
	wire hit_serial_a = addr == `PPRS_ADDR_SERIAL_A;
	wire hit_serial_b = addr == `PPRS_ADDR_SERIAL_B;
	wire hit_spi      = addr == `PPRS_ADDR_SPI;
	wire hit_two_wire = addr == `PPRS_ADDR_TWO_WIRE;

	// Only the fields this block owns are stored; the rest read zero
	wire [7:0] wmask =
		hit_table    ? `PPRS_MASK_TABLE    :
		hit_serial_a ? `PPRS_MASK_SERIAL_A :
		hit_serial_b ? `PPRS_MASK_SERIAL_B :
		hit_spi      ? `PPRS_MASK_SPI      :
		hit_two_wire ? `PPRS_MASK_TWO_WIRE : 8'h00;
	wire [7:0] wval = wdata & wmask;

	// Unmapped offsets read zero
	wire [7:0] rsel =
		hit_table    ? table_q    :
		hit_serial_a ? serial_a_q :
		hit_serial_b ? serial_b_q :
		hit_spi      ? spi_q      :
		hit_two_wire ? two_wire_q : 8'h00;

	// Reads have no side effects and return zero between reads
	wire [7:0] rdata_d = rd_en ? rsel : 8'h00;

	// Code 2 is stored as written so software reads back what it wrote
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			table_q    <= `PPRS_RESET_VAL;
			serial_a_q <= `PPRS_RESET_VAL;
			serial_b_q <= `PPRS_RESET_VAL;
			spi_q      <= `PPRS_RESET_VAL;
			two_wire_q <= `PPRS_RESET_VAL;
		end else if (wr_en) begin
			if (hit_table) begin
				table_q <= wval;
			end
			if (hit_serial_a) begin
				serial_a_q <= wval;
			end
			if (hit_serial_b) begin
				serial_b_q <= wval;
			end
			if (hit_spi) begin
				spi_q <= wval;
			end
			if (hit_two_wire) begin
				two_wire_q <= wval;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign rdata = rdata_q;

	// ****************************************
	// Field decode
	// ****************************************
	// Maps decode straight from the registers: a write acts next cycle
	wire       table0_alt = table_q[`PPRS_TABLE0_BIT];
	wire       table1_alt = table_q[`PPRS_TABLE1_BIT];
	wire [1:0] ser0_code  = serial_a_q[`PPRS_SERIAL0_LSB +: 2];
	wire [1:0] ser1_code  = serial_a_q[`PPRS_SERIAL1_LSB +: 2];
	wire [1:0] ser2_code  = serial_a_q[`PPRS_SERIAL2_LSB +: 2];
	wire [1:0] ser3_code  = serial_a_q[`PPRS_SERIAL3_LSB +: 2];
	wire [1:0] ser4_code  = serial_b_q[`PPRS_SERIAL4_LSB +: 2];
	wire [1:0] spia_code  = spi_q[`PPRS_SPI_FIRST_LSB +: 2];
	wire [1:0] spib_code  = spi_q[`PPRS_SPI_SECOND_LSB +: 2];
	wire [1:0] tw_code    = two_wire_q[`PPRS_TWO_WIRE_LSB +: 2];

	wire [23:0] off_map = {4{`PPRS_NOPIN}};

	// ****************************************
	// Lane maps
	// ****************************************
	// Table lanes: in0, in1, in2, out. Serial: tx, rx, clock, direction.
	// SPI: mosi, miso, sck, ss. Two-wire: sda, scl, dual sda, dual scl.
	pprs_pkg::pprs_map_t unit_map [`PPRS_NUM_UNITS];

	// Alternate table position moves only the output; inputs stay put
	wire [23:0] pa_in3 = pprs_seq(`PPRS_PA, 3'd3);
	wire [23:0] pc_in3 = pprs_seq(`PPRS_PC, 3'd3);

	assign unit_map[pprs_pkg::PPRS_U_TABLE0] = table0_alt ?
		{`PPRS_PA + 6'h06, pa_in3[17:0]} :
		pprs_seq(`PPRS_PA, 3'd4);
	assign unit_map[pprs_pkg::PPRS_U_TABLE1] = table1_alt ?
		{`PPRS_PC + 6'h06, pc_in3[17:0]} :
		pprs_seq(`PPRS_PC, 3'd4);
	assign unit_map[pprs_pkg::PPRS_U_SERIAL0] = pprs_pick(ser0_code,
		pprs_seq(`PPRS_PA, 3'd4),
		pprs_seq(`PPRS_PA + 6'h04, 3'd4), off_map);
	assign unit_map[pprs_pkg::PPRS_U_SERIAL1] = pprs_pick(ser1_code,
		pprs_seq(`PPRS_PC, 3'd4),
		pprs_seq(`PPRS_PC + 6'h04, 3'd4), off_map);
	assign unit_map[pprs_pkg::PPRS_U_SERIAL2] = pprs_pick(ser2_code,
		pprs_seq(`PPRS_PF, 3'd4),
		pprs_seq(`PPRS_PF + 6'h04, 3'd2), off_map);
	assign unit_map[pprs_pkg::PPRS_U_SERIAL3] = pprs_pick(ser3_code,
		pprs_seq(`PPRS_PB, 3'd4),
		pprs_seq(`PPRS_PB + 6'h04, 3'd2), off_map);
	assign unit_map[pprs_pkg::PPRS_U_SERIAL4] = pprs_pick(ser4_code,
		pprs_seq(`PPRS_PE, 3'd4),
		pprs_seq(`PPRS_PE + 6'h04, 3'd4), off_map);
	assign unit_map[pprs_pkg::PPRS_U_SPI_A] = pprs_pick(spia_code,
		pprs_seq(`PPRS_PA + 6'h04, 3'd4),
		pprs_seq(`PPRS_PE, 3'd4), off_map);
	assign unit_map[pprs_pkg::PPRS_U_SPI_B] = pprs_pick(spib_code,
		pprs_seq(`PPRS_PC, 3'd4),
		pprs_seq(`PPRS_PC + 6'h04, 3'd4), off_map);

	wire [23:0] tw_pf = pprs_seq(`PPRS_PF + 6'h02, 3'd2);
	wire [23:0] tw_pb = pprs_seq(`PPRS_PB + 6'h02, 3'd2);

	// Reserved code 3 parks the two-wire unit off all pins
	assign unit_map[pprs_pkg::PPRS_U_TWO_WIRE] = pprs_pick(tw_code,
		{tw_pb[11:0], tw_pf[11:0]}, tw_pf, tw_pb);

	// ****************************************
	// Pin input synchroniser
	// ****************************************
	// Three stages; a change counts only when stages two and three agree
	// Stage one may go metastable; nothing but stage two reads it
	logic [39:0] sync1_q;
	logic [39:0] sync2_q;
	logic [39:0] sync3_q;
	logic [39:0] filt_q;

	wire [39:0] agree  = ~(sync2_q ^ sync3_q);
	wire [39:0] filt_d = (agree & sync3_q) | (~agree & filt_q);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sync1_q <= 40'h00_0000_0000;
			sync2_q <= 40'h00_0000_0000;
			sync3_q <= 40'h00_0000_0000;
			filt_q  <= 40'h00_0000_0000;
		end else begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			filt_q  <= filt_d;
		end
	end

	// ****************************************
	// Unit routers
	// ****************************************
	// One router per unit; all share the filtered pin levels
	logic [39:0] drv_o_u  [`PPRS_NUM_UNITS];
	logic [39:0] drv_oe_u [`PPRS_NUM_UNITS];
	logic [39:0] unit_i_d;

	genvar g;
	generate
		for (g = 0; g < `PPRS_NUM_UNITS; g++) begin : g_unit
			pprs_lane_if lane_bus ();
			assign lane_bus.map    = unit_map[g];
			assign lane_bus.o      = unit_o[g*4 +: 4];
			assign lane_bus.oe     = unit_oe[g*4 +: 4];
			assign lane_bus.pin_in = filt_q;
			assign unit_i_d[g*4 +: 4] = lane_bus.i;
			assign drv_o_u[g]      = lane_bus.drv_o;
			assign drv_oe_u[g]     = lane_bus.drv_oe;
			pprs_route4 u_route (
				.lanes (lane_bus.route)
			);
		end
	endgenerate

	// ****************************************
	// Pin drive merge
	// ****************************************
	// Overlapping placements are wired-OR; software is expected to avoid
	// them, and OR keeps the result defined rather than picking a winner
	logic [39:0] pin_out_d;
	logic [39:0] pin_oe_d;

	always_comb begin
		pin_out_d = 40'h00_0000_0000;
		pin_oe_d  = 40'h00_0000_0000;
		for (int u = 0; u < `PPRS_NUM_UNITS; u++) begin
			pin_out_d = pin_out_d | drv_o_u[u];
			pin_oe_d  = pin_oe_d | drv_oe_u[u];
		end
	end

	// ****************************************
	// Output registers
	// ****************************************
	// One edge of delay keeps every output straight off a flip-flop, so
	// a route change never shows a half-decoded glitch on the pins
	logic [39:0] pin_out_q;
	logic [39:0] pin_oe_q;
	logic [39:0] unit_i_q;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pin_out_q <= 40'h00_0000_0000;
			pin_oe_q  <= 40'h00_0000_0000;
			unit_i_q  <= 40'h00_0000_0000;
		end else begin
			pin_out_q <= pin_out_d;
			pin_oe_q  <= pin_oe_d;
			unit_i_q  <= unit_i_d;
		end
	end

	assign pin_out = pin_out_q;
	assign pin_oe  = pin_oe_q;
	assign unit_i  = unit_i_q;

endmodule

// *** pprs_checker.sv ***
`timescale 1ns/100ps

// ****************************************
// Port checker
// ****************************************
module pprs_checker (
	// Clock and reset
	input logic        clk_sys,
	input logic        rst,
	// Register port
	input logic [7:0]  addr,
	input logic [7:0]  wdata,
	input logic        wr_en,
	input logic        rd_en,
	input logic [7:0]  rdata,
	// Lanes and pins
	input logic [39:0] unit_o,
	input logic [39:0] unit_oe,
	input logic [39:0] unit_i,
	input logic [39:0] pin_in,
	input logic [39:0] pin_out,
	input logic [39:0] pin_oe
);
	logic [7:0] sa_q;
	logic [7:0] sp_q;
	logic [7:0] tw_q;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	// Shadow copies, so pin checks need no look inside the design
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sa_q <= 8'h00;
			sp_q <= 8'h00;
			tw_q <= 8'h00;
		end else if (wr_en) begin
			if (addr == 8'h02) sa_q <= wdata;
			if (addr == 8'h04) sp_q <= wdata;
			if (addr == 8'h05) tw_q <= wdata;
		end
	end

	// Eight steady samples cover the three sync stages and the filter
	sequence rx_steady;
		($stable(pin_in[1]) && sa_q[1:0] == 2'b00) [*8];
	endsequence

	read_idle_a: assert property (!$past(rd_en) |-> rdata == 8'h00)
		else $error("read data not zero outside a read");
	unmapped_read_a: assert property ($past(rd_en &&
		(addr == 8'h00 || addr > 8'h05)) |-> rdata == 8'h00)
		else $error("unmapped read not zero");
	read_back_a: assert property ($past(rd_en && addr == 8'h02) |->
		rdata == $past(sa_q))
		else $error("serial route read back wrong");
	ser0_default_a: assert property ($past(sa_q[1:0] == 2'b00 &&
		unit_oe[8]) |-> pin_oe[0])
		else $error("serial 0 default not on its pin");
	ser0_alt_a: assert property ($past(sa_q[1:0] == 2'b01 &&
		unit_oe[8]) |-> pin_oe[4])
		else $error("serial 0 alternate not on its pin");
	ser3_alt_a: assert property ($past(sa_q[7:6] == 2'b01 &&
		unit_oe[20] && unit_o[20]) |-> pin_out[12])
		else $error("serial 3 alternate transmit not driven");
	spi_first_alt_a: assert property ($past(sp_q[1:0] == 2'b01 &&
		unit_oe[28]) |-> pin_oe[24])
		else $error("first spi alternate not on its pin");
	two_wire_alt_a: assert property ($past(tw_q[3:2] == 2'b10 &&
		unit_oe[36]) |-> pin_oe[10])
		else $error("two-wire second alternate not on its pin");
	all_off_a: assert property ($past(sa_q == 8'hff &&
		sp_q[3:0] == 4'hf && tw_q[3:2] == 2'b11 && unit_oe[7:0] == 8'h00
		&& unit_oe[27:24] == 4'h0) |-> pin_oe == 40'h0)
		else $error("pin driven while all units are off");
	rx_return_a: assert property (rx_steady |-> unit_i[9] == pin_in[1])
		else $error("serial 0 receive lane does not follow its pin");
endmodule

// *** pprs_top_tb.sv ***
`timescale 1ns/100ps

module pprs_top_tb;
	// ****************************************
	// Signals
	// ****************************************
	typedef struct {
		logic [1:0]  k;
		logic [39:0] v;
		logic [39:0] m;
	} pprs_note_s;
	logic        clk_sys;
	logic        rst;
	logic [7:0]  addr;
	logic [7:0]  wdata;
	logic        wr_en;
	logic        rd_en;
	logic [7:0]  rdata;
	logic [39:0] unit_o;
	logic [39:0] unit_oe;
	logic [39:0] unit_i;
	logic [39:0] pin_in;
	logic [39:0] pin_out;
	logic [39:0] pin_oe;
	logic        rd_d = 1'b0;
	logic [1:0]  look;
	logic [7:0]  lf;
	logic [39:0] ex;
	logic [39:0] oe;
	int          n_mismatch;
	int          cmp_count;
	pprs_note_s  q[$];
	pprs_note_s  nt;
	logic [7:0]  mk [8] = '{8'h00, 8'h03, 8'hff, 8'h03, 8'h0f, 8'h0c,
		8'h00, 8'h00};
	logic [7:0]  ua [10] = '{8'h01, 8'h01, 8'h02, 8'h02, 8'h02, 8'h02,
		8'h03, 8'h04, 8'h04, 8'h05};
	int          ul [10] = '{0, 1, 0, 2, 4, 6, 0, 0, 2, 2};
	logic [39:0] dm [10] = '{40'h8, 40'h80000, 40'hf, 40'hf0000,
		40'hf00000000, 40'hf00, 40'hf000000, 40'hf0, 40'hf0000,
		40'hc00000c00};
	logic [39:0] am [10] = '{40'h40, 40'h400000, 40'hf0, 40'hf00000,
		40'h3000000000, 40'h3000, 40'hf0000000, 40'hf000000, 40'hf00000,
		40'hc00000000};

	pprs_top pprs_top_inst (.clk_sys(clk_sys), .rst(rst), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
		.unit_o(unit_o), .unit_oe(unit_oe), .unit_i(unit_i),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// ****************************************
	// Tasks
	// ****************************************
	function automatic logic [7:0] nx(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction

	task automatic check(input logic [39:0] seen, input logic [39:0] want);
		cmp_count++;
		if (seen !== want) begin
			n_mismatch++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk_sys);
		wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		rd_en <= 1'b1;
		addr <= a;
		q.push_back('{2'd0, {32'h0, e}, 40'hff});
		@(posedge clk_sys);
		rd_en <= 1'b0;
	endtask

	// Pin mapping is registered behind the route register: look late
	task automatic expect_at(input logic [1:0] k, input logic [39:0] v,
		input logic [39:0] m);
		@(posedge clk_sys);
		look <= k;
		q.push_back('{k, v, m});
		@(posedge clk_sys);
		look <= 2'b00;
	endtask

	task automatic tally_and_finish;
		if (q.size() != 0) n_mismatch++;
		$display("counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ****************************************
	// Monitor
	// ****************************************
	always @(posedge clk_sys) begin
		if (rd_d || look != 2'b00) begin
			if (q.size() == 0) begin
				n_mismatch++;
				$display("unexpected at %0t: result with no note", $time);
			end else begin
				nt = q.pop_front();
				if (nt.k == 2'd0) check({32'h0, rdata} & nt.m, nt.v);
				if (nt.k == 2'd1) check(pin_oe & nt.m, nt.v);
				if (nt.k == 2'd1) check(pin_out & nt.m, nt.v);
				if (nt.k == 2'd2) check(unit_i & nt.m, nt.v);
			end
		end
		rd_d <= rd_en;
	end

	initial begin
		repeat (5000) @(posedge clk_sys);
		n_mismatch++;
		tally_and_finish();
	end

	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		{rst, wr_en, rd_en, addr, wdata, look} = {3'h4, 18'h0};
		{unit_o, unit_oe, pin_in} = '0;
		{n_mismatch, cmp_count} = '0;
		lf = 8'h3d;
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		for (int a = 0; a < 8; a++) rd(a[7:0], 8'h00);
		$display("test reset_values done");
		repeat (4) for (int a = 0; a < 8; a++) begin
			lf = nx(lf);
			wr(a[7:0], lf);
			rd(a[7:0], lf & mk[a]);
		end
		$display("test read_back done");
		for (int u = 0; u < 10; u++) for (int c = 0; c < 4; c++) begin
			if (u < 2 && c > 1) continue;
			ex = (c == 0) ? dm[u] : (c == 1) ? am[u] : 40'h0;
			if (u == 9 && c == 2) ex = 40'hc00;
			oe = ((u < 2) ? 40'h8 : 40'hf) << (4 * u);
			unit_oe <= oe;
			unit_o <= oe;
			wr(ua[u], 8'(c << ul[u]));
			expect_at(2'd1, ex, '1);
		end
		$display("test code_sweep done");
		// Table and serial 4 lanes stay quiet so no pin may light up
		unit_oe <= 40'hfff0ffff00;
		unit_o <= 40'hfff0ffff00;
		wr(8'h02, 8'hff);
		wr(8'h04, 8'h0f);
		wr(8'h05, 8'h0c);
		expect_at(2'd1, 40'h0, '1);
		$display("test all_off done");
		for (int i = 0; i < 4; i++) begin
			lf = nx(lf);
			pin_in <= {5{lf}};
			unit_o <= {5{~lf}};
			wr(8'h02, i[0] ? 8'h03 : 8'h00);
			repeat (7) @(posedge clk_sys);
			expect_at(2'd2, i[0] ? 40'h0 : {30'h0, lf[1], 9'h0}, 40'h200);
		end
		$display("test receive_path done");
		repeat (3) @(posedge clk_sys);
		tally_and_finish();
	end
endmodule

bind pprs_top pprs_checker pprs_checker_inst (.clk_sys(clk_sys), .rst(rst),
	.addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
	.rdata(rdata), .unit_o(unit_o), .unit_oe(unit_oe), .unit_i(unit_i),
	.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
